// ### hdl/shfc_pkg.sv
// Purpose: shared constants for the serial host port with hold-off flow control
// Assumes: one clock, synchronous active-high reset
// Notes:   every frame is 11 bits: start, 8 data/parity bits, two stops
package shfc_pkg;

	localparam int          CLK_HZ_DEFAULT  = 200_000_000;
	localparam int          RX_FULL_CHARS   = 100;
	localparam int          RESP_MAX_CHARS  = 80;
	localparam int          TX_FIFO_DEPTH   = 8;
	localparam int          KEY_COUNT       = 8;
	localparam int          LOCAL_KEY_INDEX = 0;
	localparam int          FRAME_BITS      = 11;
	localparam int          DIV_W           = 20;

	// baud rates and their select codes
	localparam int          RATE_300        = 300;
	localparam int          RATE_600        = 600;
	localparam int          RATE_1200       = 1200;
	localparam int          RATE_2400       = 2400;
	localparam int          RATE_4800       = 4800;
	localparam int          RATE_9600       = 9600;
	localparam logic [2:0]  BAUD_300        = 3'h0;
	localparam logic [2:0]  BAUD_600        = 3'h1;
	localparam logic [2:0]  BAUD_1200       = 3'h2;
	localparam logic [2:0]  BAUD_2400       = 3'h3;
	localparam logic [2:0]  BAUD_4800       = 3'h4;
	localparam logic [2:0]  BAUD_9600       = 3'h5;

	// parity select codes; parity also fixes the data width
	localparam logic [1:0]  PAR_NONE_8      = 2'h0;
	localparam logic [1:0]  PAR_EVEN_7      = 2'h1;
	localparam logic [1:0]  PAR_ODD_7       = 2'h2;

	// characters the port itself acts on
	localparam logic [7:0]  CHAR_CANCEL     = 8'h03;
	localparam logic [7:0]  CHAR_NL         = 8'h0A;
	localparam logic [7:0]  CHAR_CR         = 8'h0D;
	localparam logic [7:0]  CHAR_DQUOTE     = 8'h22;
	localparam logic [7:0]  CHAR_SQUOTE     = 8'h27;
	localparam logic [7:0]  CHAR_ZERO       = 8'h30;
	localparam logic [7:0]  CHAR_SEMI       = 8'h3B;
	localparam logic [7:0]  CHAR_QUERY      = 8'h3F;
	localparam logic [7:0]  CHAR_LOW_A      = 8'h61;
	localparam logic [7:0]  CHAR_LOW_Z      = 8'h7A;
	localparam logic [7:0]  CASE_BIT        = 8'h20;

	typedef enum logic [1:0] {MODE_LOCAL, MODE_REMOTE, MODE_LOCKOUT} shfc_mode_t;

endpackage : shfc_pkg

// ### hdl/shfc_fifo.sv
// Purpose: small synchronous FIFO with a registered head word
// Assumes: DEPTH is a power of two; flush drops everything at once
// Notes:   capacity is DEPTH in memory plus the head register
`timescale 1ns/10ps
module shfc_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
)(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("shfc_fifo: DEPTH must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             load;
	logic             bypass;
	logic             wr_mem;
	logic             rd_mem;

	// head register refills whenever it is empty or being taken
	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign push      = in_valid & in_ready;
	assign load      = ~out_valid | out_ready;
	assign bypass    = load & (cnt_q == '0);
	assign rd_mem    = load & (cnt_q != '0);
	assign wr_mem    = push & ~bypass;

	always_ff @(posedge clk) begin
		if (wr_mem)
			mem_q[wr_q] <= in_data;
	end

	// pointers, fill count and the head word
	always_ff @(posedge clk) begin
		if (rst | flush) begin
			wr_q      <= '0;
			rd_q      <= '0;
			cnt_q     <= '0;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			if (wr_mem)
				wr_q <= wr_q + 1'b1;
			if (rd_mem)
				rd_q <= rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(wr_mem) - (AW+1)'(rd_mem);
			if (load) begin
				out_valid <= rd_mem | push;
				out_data  <= rd_mem ? mem_q[rd_q] : in_data;
			end
		end
	end

endmodule : shfc_fifo

// ### hdl/shfc_serial_port.sv
// Purpose: serial host port: framing, hold-off flow control, message tracking
// Assumes: parser pulses remote/local commands and rx_consumed; pins unsynchronised
// Notes:   dtr_pin/dsr_pin high means TRUE; line idles high
// Functional notes
// - receive buffer full: drop terminal-ready
// - space freed: raise terminal-ready unless talking
// - query answered: terminal-ready false until sent
// - check host ready before each character
// - suspended output keeps terminal-ready false
// - cancel aborts and discards pending output
// - one start bit, two stop bits
// - commands accepted only after remote mode
// - key lockout by local/remote/lockout mode
// - newline terminates; CR then newline accepted
// - termination resets command path to root
// - semicolon keeps the command path
// - respond only after a query
// - boolean answers are single 0 or 1
// - accept mixed case, fold to upper outside quoted strings
// - quoted strings; doubled quote is literal
// - responses end CR newline; short ones capped
// - six selectable baud rates, 9600 default
// - parity choice fixes seven or eight data bits
// - after cancel terminal-ready returns true
`timescale 1ns/10ps
module shfc_serial_port
	import shfc_pkg::*;
#(
	parameter int CLK_HZ    = CLK_HZ_DEFAULT,
	parameter int RX_FULL   = RX_FULL_CHARS,
	parameter int RESP_MAX  = RESP_MAX_CHARS,
	parameter int TX_DEPTH  = TX_FIFO_DEPTH,
	parameter int KEYS      = KEY_COUNT,
	parameter int LOCAL_KEY = LOCAL_KEY_INDEX
)(
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire logic [2:0]      baud_sel,
	input  wire logic [1:0]      parity_sel,
	input  wire logic            rxd_pin,
	output logic                 txd_pin,
	output logic                 dtr_pin,
	input  wire logic            dsr_pin,
	output logic                 rx_valid,
	output logic [7:0]           rx_data,
	output logic                 rx_in_string,
	output logic                 rx_parity_err,
	input  wire logic            rx_consumed,
	output logic                 rx_full,
	output logic                 msg_end,
	output logic                 cmd_sep,
	input  wire logic            remote_command,
	input  wire logic            local_command,
	input  wire logic            remote_lockout_command,
	output logic                 cmd_enable,
	input  wire logic [KEYS-1:0] key_in,
	output logic [KEYS-1:0]      key_out,
	input  wire logic            tx_valid,
	output logic                 tx_ready,
	input  wire logic [7:0]      tx_data,
	input  wire logic            tx_bool,
	input  wire logic            tx_reading,
	input  wire logic            tx_last,
	output logic                 talk_active,
	output logic                 dev_clear
);
	initial begin
		if (CLK_HZ / RATE_300 >= (1 << DIV_W) || CLK_HZ / RATE_9600 < 4)
			$error("shfc_serial_port: CLK_HZ outside divider range");
		if (RX_FULL < 2 || RX_FULL > 255 || RESP_MAX < 2 || RESP_MAX > 255)
			$error("shfc_serial_port: RX_FULL/RESP_MAX out of range");
		if (LOCAL_KEY >= KEYS)
			$error("shfc_serial_port: LOCAL_KEY beyond KEYS");
	end

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} shfc_rx_state_t;
	typedef enum logic {TX_IDLE, TX_SHIFT} shfc_tx_state_t;

	// bit period in clocks for the selected rate
	function automatic logic [DIV_W-1:0] shfc_div(input logic [2:0] code);
		unique case (code)
			BAUD_300:  return DIV_W'(CLK_HZ / RATE_300);
			BAUD_600:  return DIV_W'(CLK_HZ / RATE_600);
			BAUD_1200: return DIV_W'(CLK_HZ / RATE_1200);
			BAUD_2400: return DIV_W'(CLK_HZ / RATE_2400);
			BAUD_4800: return DIV_W'(CLK_HZ / RATE_4800);
			default:   return DIV_W'(CLK_HZ / RATE_9600);
		endcase
	endfunction : shfc_div

	logic [DIV_W-1:0] div_q;
	logic [1:0]       rxd_sync_q;
	logic [1:0]       dsr_sync_q;
	logic             rxd_s;
	logic             dsr_s;

	// illegal select codes fall back to the default rate
	always_ff @(posedge clk) begin
		if (rst)
			div_q <= DIV_W'(CLK_HZ / RATE_9600);
		else
			div_q <= shfc_div(baud_sel);
	end

	// pin synchronisers; idle-high reset avoids a false start bit
	always_ff @(posedge clk) begin
		if (rst) begin
			rxd_sync_q <= 2'h3;
			dsr_sync_q <= 2'h0;
		end else begin
			rxd_sync_q <= {rxd_sync_q[0], rxd_pin};
			dsr_sync_q <= {dsr_sync_q[0], dsr_pin};
		end
	end
	assign rxd_s = rxd_sync_q[1];
	assign dsr_s = dsr_sync_q[1];

	// ---------------- receiver ----------------
	shfc_rx_state_t   rx_st_q;
	logic [DIV_W-1:0] rx_cnt_q;
	logic [3:0]       rx_bit_q;
	logic [9:0]       rx_sh_q;
	logic             rx_done_q;
	logic [7:0]       rx_char;
	logic             par_bad;
	logic             rx_good;
	logic             cancel_ev;
	logic             chr_ev;

	// mid-bit sampling: half period to the start centre, then full periods
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_st_q   <= RX_IDLE;
			rx_cnt_q  <= '0;
			rx_bit_q  <= '0;
			rx_sh_q   <= '0;
			rx_done_q <= 1'b0;
		end else begin
			rx_done_q <= 1'b0;
			unique case (rx_st_q)
				RX_IDLE: begin
					if (!rxd_s) begin
						rx_cnt_q <= div_q >> 1;
						rx_st_q  <= RX_START;
					end
				end
				RX_START: begin
					if (rx_cnt_q != '0) begin
						rx_cnt_q <= rx_cnt_q - 1'b1;
					end else if (!rxd_s) begin
						rx_cnt_q <= div_q - 1'b1;
						rx_bit_q <= '0;
						rx_st_q  <= RX_BITS;
					end else begin
						rx_st_q <= RX_IDLE; // glitch, not a start bit
					end
				end
				RX_BITS: begin
					if (rx_cnt_q != '0) begin
						rx_cnt_q <= rx_cnt_q - 1'b1;
					end else begin
						rx_sh_q  <= {rxd_s, rx_sh_q[9:1]};
						rx_cnt_q <= div_q - 1'b1;
						rx_bit_q <= rx_bit_q + 1'b1;
						if (rx_bit_q == 4'h9) begin
							rx_done_q <= 1'b1;
							rx_st_q   <= RX_IDLE;
						end
					end
				end
			endcase
		end
	end

	// decode: 7 data bits plus parity, or 8 data bits
	always_comb begin
		rx_char = rx_sh_q[7:0];
		par_bad = 1'b0;
		if (parity_sel != PAR_NONE_8) begin
			rx_char = {1'b0, rx_sh_q[6:0]};
			par_bad = (parity_sel == PAR_ODD_7) ? ~^rx_sh_q[7:0] : ^rx_sh_q[7:0];
		end
	end

	// both stop bits must be high or the frame is dropped
	assign rx_good   = rx_done_q & rx_sh_q[8] & rx_sh_q[9];
	assign cancel_ev = rx_good & (rx_char == CHAR_CANCEL);
	assign chr_ev    = rx_good & ~cancel_ev;

	// ---------------- message tracking ----------------
	logic       in_str_q;
	logic [7:0] quote_q;
	logic       query_q;
	logic       talk_q;
	logic       is_nl;
	logic       is_quote;
	logic       tx_lf_done;

	assign is_nl    = (rx_char == CHAR_NL);
	assign is_quote = (rx_char == CHAR_SQUOTE) || (rx_char == CHAR_DQUOTE);

	// a doubled delimiter leaves then re-enters the string, so it stays literal
	always_ff @(posedge clk) begin
		if (rst || cancel_ev || (chr_ev && is_nl)) begin
			in_str_q <= 1'b0;
			quote_q  <= '0;
		end else if (chr_ev) begin
			if (in_str_q && rx_char == quote_q)
				in_str_q <= 1'b0;
			else if (!in_str_q && is_quote) begin
				in_str_q <= 1'b1;
				quote_q  <= rx_char;
			end
		end
	end

	// a query seen before the newline makes the port talk
	// a fresh query newline wins over the end of the old reply, so it is not lost
	always_ff @(posedge clk) begin
		if (rst || cancel_ev) begin
			query_q <= 1'b0;
			talk_q  <= 1'b0;
		end else begin
			if (tx_lf_done)
				talk_q <= 1'b0;
			if (chr_ev && is_nl) begin
				query_q <= 1'b0;
				if (query_q)
					talk_q <= 1'b1;
			end else if (chr_ev && !in_str_q && rx_char == CHAR_QUERY) begin
				query_q <= 1'b1;
			end
		end
	end

	// registered character stream for the parser
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_valid      <= 1'b0;
			rx_data       <= '0;
			rx_in_string  <= 1'b0;
			rx_parity_err <= 1'b0;
			msg_end       <= 1'b0;
			cmd_sep       <= 1'b0;
			dev_clear     <= 1'b0;
		end else begin
			rx_valid      <= chr_ev;
			rx_in_string  <= in_str_q;
			rx_parity_err <= chr_ev & par_bad;
			// CR passes as data; only the newline ends a message
			msg_end       <= chr_ev & is_nl;
			cmd_sep       <= chr_ev & ~in_str_q & (rx_char == CHAR_SEMI);
			dev_clear     <= cancel_ev;
			if (!in_str_q && rx_char >= CHAR_LOW_A && rx_char <= CHAR_LOW_Z)
				rx_data <= rx_char & ~CASE_BIT;
			else
				rx_data <= rx_char;
		end
	end

	// ---------------- receive occupancy ----------------
	logic [7:0] rx_cnt_chars_q;

	// counts characters the parser has not consumed yet; saturates
	always_ff @(posedge clk) begin
		if (rst || cancel_ev)
			rx_cnt_chars_q <= '0;
		else if (chr_ev && !rx_consumed && rx_cnt_chars_q != 8'hFF)
			rx_cnt_chars_q <= rx_cnt_chars_q + 1'b1;
		else if (!chr_ev && rx_consumed && rx_cnt_chars_q != '0)
			rx_cnt_chars_q <= rx_cnt_chars_q - 1'b1;
	end
	assign rx_full = (rx_cnt_chars_q >= 8'(RX_FULL));

	// ---------------- mode and keys ----------------
	shfc_mode_t mode_q;

	// the local key itself drops remote mode, but never lockout
	always_ff @(posedge clk) begin
		if (rst)
			mode_q <= MODE_LOCAL;
		else if (remote_lockout_command)
			mode_q <= MODE_LOCKOUT;
		else if (remote_command)
			mode_q <= MODE_REMOTE;
		else if (local_command || (mode_q == MODE_REMOTE && key_in[LOCAL_KEY]))
			mode_q <= MODE_LOCAL;
	end
	assign cmd_enable = (mode_q != MODE_LOCAL);

	always_ff @(posedge clk) begin
		if (rst)
			key_out <= '0;
		else
			unique case (mode_q)
				MODE_LOCAL:   key_out <= key_in;
				MODE_REMOTE:  key_out <= key_in & (KEYS'(1) << LOCAL_KEY);
				MODE_LOCKOUT: key_out <= '0;
				default:      key_out <= '0;
			endcase
	end

	// ---------------- response write side ----------------
	logic       closed_q;
	logic [7:0] resp_len_q;
	logic [7:0] tx_char;
	logic       keep;
	logic       push_ok;
	logic       f_in_ready;
	logic       f_out_valid;
	logic       f_out_ready;
	logic [8:0] f_out_data;

	// writes are refused outside a query answer
	assign tx_ready = talk_q & ~closed_q & f_in_ready;
	assign tx_char  = tx_bool ? (CHAR_ZERO | {7'h0, tx_data[0]}) : tx_data;
	// short answers are capped; the overflow is swallowed, the last kept
	assign keep     = tx_last | tx_reading | (resp_len_q < 8'(RESP_MAX - 1));
	assign push_ok  = tx_valid & tx_ready;

	always_ff @(posedge clk) begin
		if (rst || cancel_ev || !talk_q || (chr_ev && is_nl && query_q)) begin
			closed_q   <= 1'b0;
			resp_len_q <= '0;
		end else if (push_ok) begin
			closed_q <= tx_last;
			if (keep)
				resp_len_q <= resp_len_q + 1'b1;
		end
	end

	shfc_fifo #(
		.WIDTH (9),
		.DEPTH (TX_DEPTH)
	) u_tx_fifo (
		.clk       (clk),
		.rst       (rst),
		.flush     (cancel_ev),
		.in_valid  (push_ok & keep),
		.in_ready  (f_in_ready),
		.in_data   ({tx_last, tx_char}),
		.out_valid (f_out_valid),
		.out_ready (f_out_ready),
		.out_data  (f_out_data)
	);

	// ---------------- transmitter ----------------
	shfc_tx_state_t       tx_st_q;
	logic [FRAME_BITS-1:0] tx_sh_q;
	logic [DIV_W-1:0]     tx_cnt_q;
	logic [3:0]           tx_bit_q;
	logic [1:0]           eol_q;
	logic                 tx_is_lf_q;
	logic                 tx_pend;
	logic                 tx_go;
	logic [7:0]           ld_char;
	logic                 ld_b8;

	assign tx_pend     = (eol_q != 2'h0) | f_out_valid;
	// host ready is checked only between characters
	assign tx_go       = (tx_st_q == TX_IDLE) & tx_pend & dsr_s & ~cancel_ev;
	assign f_out_ready = tx_go & (eol_q == 2'h0);
	assign tx_lf_done  = (tx_st_q == TX_SHIFT) & (tx_cnt_q == '0) &
	                     (tx_bit_q == 4'hA) & tx_is_lf_q;

	// character to load and its eighth bit (data or parity)
	always_comb begin
		ld_char = f_out_data[7:0];
		if (eol_q == 2'h2)
			ld_char = CHAR_CR;
		else if (eol_q == 2'h1)
			ld_char = CHAR_NL;
		unique case (parity_sel)
			PAR_EVEN_7: ld_b8 = ^ld_char[6:0];
			PAR_ODD_7:  ld_b8 = ~^ld_char[6:0];
			default:    ld_b8 = ld_char[7];
		endcase
	end

	// frame: start, 8 bits LSB first, two stops; cancel drops mid-frame
	always_ff @(posedge clk) begin
		if (rst || cancel_ev) begin
			tx_st_q    <= TX_IDLE;
			tx_sh_q    <= '1;
			tx_cnt_q   <= '0;
			tx_bit_q   <= '0;
			eol_q      <= 2'h0;
			tx_is_lf_q <= 1'b0;
		end else begin
			unique case (tx_st_q)
				TX_IDLE: begin
					if (tx_go) begin
						tx_sh_q    <= {2'h3, ld_b8, ld_char[6:0], 1'b0};
						tx_cnt_q   <= div_q - 1'b1;
						tx_bit_q   <= '0;
						tx_st_q    <= TX_SHIFT;
						tx_is_lf_q <= (eol_q == 2'h1);
						if (eol_q != 2'h0)
							eol_q <= eol_q - 1'b1;
						else if (f_out_data[8])
							eol_q <= 2'h2;
					end
				end
				TX_SHIFT: begin
					if (tx_cnt_q != '0) begin
						tx_cnt_q <= tx_cnt_q - 1'b1;
					end else begin
						tx_sh_q  <= {1'b1, tx_sh_q[FRAME_BITS-1:1]};
						tx_cnt_q <= div_q - 1'b1;
						tx_bit_q <= tx_bit_q + 1'b1;
						if (tx_bit_q == 4'hA)
							tx_st_q <= TX_IDLE;
					end
				end
			endcase
		end
	end

	// ---------------- pins ----------------
	// terminal-ready is true only when none of the three hold-off causes is present
	always_ff @(posedge clk) begin
		if (rst) begin
			txd_pin <= 1'b1;
			dtr_pin <= 1'b0;
		end else begin
			txd_pin <= tx_sh_q[0];
			dtr_pin <= ~rx_full & ~talk_q & ~(tx_pend & ~dsr_s);
		end
	end
	assign talk_active = talk_q;

endmodule : shfc_serial_port

// ### bench/shfc_serial_port_sva.sv
// Purpose: port-level assertions for the serial host port
// Assumes: one clock, synchronous active-high reset
// Notes:   dtr_pin and key_out are registered, so causes show one edge later
`timescale 1ns/10ps
module shfc_port_chk
	import shfc_pkg::*;
#(
	parameter int KEYS = 8
)(
	input wire logic            clk,
	input wire logic            rst,
	input wire logic            txd_pin,
	input wire logic            dtr_pin,
	input wire logic            rx_valid,
	input wire logic [7:0]      rx_data,
	input wire logic            rx_in_string,
	input wire logic            rx_full,
	input wire logic            msg_end,
	input wire logic            cmd_sep,
	input wire logic            cmd_enable,
	input wire logic [KEYS-1:0] key_in,
	input wire logic [KEYS-1:0] key_out,
	input wire logic            tx_ready,
	input wire logic            talk_active,
	input wire logic            dev_clear
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// everything a cancel must leave behind, checked together
	sequence s_cleared;
		dtr_pin && txd_pin && !talk_active && !rx_full;
	endsequence

	property p_full_hold;      rx_full |=> !dtr_pin; endproperty
	property p_space_back;     $fell(rx_full) && !talk_active |-> ##[0:2] dtr_pin; endproperty
	property p_talk_hold;      talk_active |=> !dtr_pin; endproperty
	property p_talk_release;   $fell(talk_active) && !rx_full |-> ##[0:2] dtr_pin; endproperty
	property p_quiet;          !talk_active && !$past(talk_active) |-> txd_pin; endproperty
	property p_ready_talk;     tx_ready |-> talk_active; endproperty
	property p_cancel;         dev_clear |=> s_cleared; endproperty
	property p_term;           msg_end |-> rx_valid && rx_data == CHAR_NL; endproperty
	property p_sep;
		cmd_sep |-> rx_valid && rx_data == CHAR_SEMI && !rx_in_string;
	endproperty
	property p_no_cancel_char; rx_valid |-> rx_data != CHAR_CANCEL; endproperty
	property p_keys_local;     !cmd_enable |=> key_out == $past(key_in); endproperty
	property p_keys_remote;    cmd_enable |=> key_out[KEYS-1:1] == '0; endproperty

	a_full_hold: assert property (p_full_hold)
		else $error("dtr stayed true with buffer full");
	a_space_back: assert property (p_space_back)
		else $error("dtr not restored after space freed");
	a_talk_hold: assert property (p_talk_hold)
		else $error("dtr true while talking");
	a_talk_release: assert property (p_talk_release)
		else $error("dtr not restored after reply");
	a_quiet: assert property (p_quiet)
		else $error("serial output active without a query");
	a_ready_talk: assert property (p_ready_talk)
		else $error("response write open outside talk");
	a_cancel: assert property (p_cancel)
		else $error("cancel left port busy");
	a_term: assert property (p_term)
		else $error("message end without newline");
	a_sep: assert property (p_sep)
		else $error("separator flag on wrong character");
	a_no_cancel_char: assert property (p_no_cancel_char)
		else $error("cancel character delivered as data");
	a_keys_local: assert property (p_keys_local)
		else $error("keys masked in local mode");
	a_keys_remote: assert property (p_keys_remote)
		else $error("non-local key passed in remote mode");
endmodule : shfc_port_chk

bind shfc_serial_port shfc_port_chk #(.KEYS(KEYS)) i_shfc_port_chk (
	.clk(clk), .rst(rst), .txd_pin(txd_pin), .dtr_pin(dtr_pin), .rx_valid(rx_valid),
	.rx_data(rx_data), .rx_in_string(rx_in_string), .rx_full(rx_full), .msg_end(msg_end),
	.cmd_sep(cmd_sep), .cmd_enable(cmd_enable), .key_in(key_in), .key_out(key_out),
	.tx_ready(tx_ready), .talk_active(talk_active), .dev_clear(dev_clear)
);

// ### bench/shfc_host_model.sv
// Purpose: host controller at the far end of the serial link
// Assumes: DIV clocks per bit, same rate as the port
// Notes:   handshake line is driven by the bench; received chars queue up
`timescale 1ns/10ps
module shfc_host_model #(
	parameter int DIV = 20
)(
	input  wire logic clk,
	output logic      to_dev,
	input  wire logic from_dev
);
	logic [7:0] got_q[$];
	logic [9:0] sh;
	int         stop_err = 0;

	initial to_dev = 1'b1;

	// one frame: start, eight bits lsb first, two stops
	task automatic send_char(input logic [7:0] c);
		logic [10:0] f;
		f = {2'b11, c, 1'b0};
		@(negedge clk);
		for (int i = 0; i < 11; i++) begin
			to_dev = f[i];
			repeat (DIV) @(negedge clk);
		end
	endtask : send_char

	// receiver samples mid-bit; a low stop bit is counted as a framing fault
	always begin
		@(negedge from_dev);
		repeat (DIV / 2) @(posedge clk);
		for (int i = 0; i < 10; i++) begin
			repeat (DIV) @(posedge clk);
			sh[i] = from_dev;
		end
		if (sh[9:8] !== 2'b11) stop_err++;
		got_q.push_back(sh[7:0]);
	end
endmodule : shfc_host_model

// ### bench/tb.sv
// Purpose: self-checking bench for the serial host port
// Assumes: clock lowered so one bit is 20 clocks at 9600 baud
// Notes:   inputs change on the falling edge; host model plays the controller
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
	$display("unexpected t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
	import shfc_pkg::*;
	localparam int DIV = 20;
	logic       clk = 1'b0, rst = 1'b1, rxd_pin, txd_pin, dtr_pin, dsr_pin = 1'b1;
	logic [2:0] baud_sel = BAUD_9600;
	logic [1:0] parity_sel = PAR_NONE_8;
	logic       rx_valid, rx_in_string, rx_parity_err, rx_full, msg_end, cmd_sep;
	logic [7:0] rx_data, key_in = 8'hA4, key_out, tx_data = 8'h00;
	logic       rx_consumed = 1'b0, remote_command = 1'b0, local_command = 1'b0;
	logic       remote_lockout_command = 1'b0, cmd_enable, tx_ready, talk_active;
	logic       tx_valid = 1'b0, tx_bool = 1'b0, tx_reading = 1'b0, tx_last = 1'b0;
	logic       dev_clear, auto_con = 1'b1, con_one = 1'b0;
	logic [8:0] rxq[$];
	int         failures = 0, n_compared = 0, n_clear = 0, n_end = 0, n_sep = 0, n_perr = 0;

	shfc_serial_port #(.CLK_HZ(DIV * RATE_9600)) i_shfc_serial_port (.*);
	shfc_host_model #(.DIV(DIV)) i_shfc_host_model (.clk(clk), .to_dev(rxd_pin),
		.from_dev(txd_pin));

	always #2.5 clk = ~clk;

	// record what the port hands to the parser, mid-cycle where the pulses stand
	always @(negedge clk) begin
		if (rx_valid) rxq.push_back({rx_in_string, rx_data});
		if (rx_valid && rx_parity_err) n_perr++;
		if (dev_clear) n_clear++;
		if (msg_end) n_end++;
		if (cmd_sep) n_sep++;
	end

	// parser stand-in frees each char, unless a test holds the buffer
	always @(negedge clk) rx_consumed <= (auto_con & rx_valid) | con_one;

	task automatic give_verdict;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict

	task automatic send_str(input string s);
		for (int i = 0; i < s.len(); i++) i_shfc_host_model.send_char(s[i]);
		repeat (10) @(negedge clk);
	endtask : send_str

	// write waits until tx_ready is settled, then one edge takes it
	task automatic write_tx(input logic [7:0] d, input logic b, input logic l);
		{tx_valid, tx_data, tx_bool, tx_last} = {1'b1, d, b, l};
		for (int i = 0; i < 100 && tx_ready !== 1'b1; i++) @(negedge clk);
		@(negedge clk);
		tx_valid = 1'b0;
	endtask : write_tx

	task automatic mode_step(input logic [2:0] p, input logic [7:0] ki, input logic [7:0] k,
		input logic en);
		{remote_command, remote_lockout_command, local_command} = p;
		key_in = ki;
		@(negedge clk);
		{remote_command, remote_lockout_command, local_command} = 3'h0;
		repeat (2) @(negedge clk);
		`CHK(cmd_enable, en)
		`CHK(key_out, k)
	endtask : mode_step

	task automatic t_modes;
		mode_step(3'h0, 8'hA4, 8'hA4, 1'b0);
		mode_step(3'h4, 8'hA4, 8'h00, 1'b1);
		mode_step(3'h2, 8'hA5, 8'h00, 1'b1);
		mode_step(3'h1, 8'hA4, 8'hA4, 1'b0);
		mode_step(3'h4, 8'hA5, 8'hA5, 1'b0);
		mode_step(3'h4, 8'hA4, 8'h00, 1'b1);
	endtask : t_modes

	task automatic t_rx;
		logic [8:0] exp_rx[10];
		int         n0;
		exp_rx = '{9'h041, 9'h03B, 9'h022, 9'h162, 9'h122,
			9'h022, 9'h13B, 9'h122, 9'h00D, 9'h00A};
		n0 = rxq.size();
		send_str("a;\"b\"\";\"\r\n");
		foreach (exp_rx[i]) `CHK(rxq[n0 + i], exp_rx[i])
		`CHK(n_sep, 1)
		`CHK(n_end, 1)
	endtask : t_rx

	// even parity, seven bits: a good frame, then one with the parity bit wrong
	task automatic t_parity;
		int n0;
		parity_sel = PAR_EVEN_7;
		n0 = rxq.size();
		send_str("A\301");
		`CHK(rxq[n0], 9'h041)
		`CHK(rxq[n0 + 1], 9'h041)
		`CHK(n_perr, 1)
		parity_sel = PAR_NONE_8;
	endtask : t_parity

	task automatic t_query;
		send_str("?\n");
		`CHK(talk_active, 1'b1)
		parity_sel = PAR_ODD_7;
		`CHK(dtr_pin, 1'b0)
		dsr_pin = 1'b0;
		repeat (4) @(negedge clk);
		write_tx(8'h01, 1'b1, 1'b1);
		repeat (5 * 11 * DIV) @(negedge clk);
		`CHK(i_shfc_host_model.got_q.size(), 0)
		`CHK(dtr_pin, 1'b0)
		dsr_pin = 1'b1;
		for (int i = 0; i < 1000 && talk_active; i++) @(negedge clk);
		repeat (3) @(negedge clk);
		`CHK(dtr_pin, 1'b1)
		`CHK(i_shfc_host_model.got_q.size(), 3)
		`CHK(i_shfc_host_model.got_q[0], 8'h31)
		`CHK(i_shfc_host_model.got_q[1], CHAR_CR)
		`CHK(i_shfc_host_model.got_q[2], 8'h80 | CHAR_NL)
		`CHK(i_shfc_host_model.stop_err, 0)
		i_shfc_host_model.got_q.delete();
		parity_sel = PAR_NONE_8;
	endtask : t_query

	task automatic t_full;
		auto_con = 1'b0;
		repeat (100) i_shfc_host_model.send_char(8'h58);
		repeat (10) @(negedge clk);
		`CHK(rx_full, 1'b1)
		`CHK(dtr_pin, 1'b0)
		@(posedge clk);
		con_one = 1'b1;
		@(posedge clk);
		con_one = 1'b0;
		repeat (4) @(negedge clk);
		`CHK(rx_full, 1'b0)
		`CHK(dtr_pin, 1'b1)
		auto_con = 1'b1;
	endtask : t_full

	task automatic t_cancel;
		int n0, r0;
		send_str("?\n");
		`CHK(talk_active, 1'b1)
		dsr_pin = 1'b0;
		repeat (4) @(negedge clk);
		write_tx(8'h41, 1'b0, 1'b1);
		n0 = n_clear;
		r0 = rxq.size();
		send_str("\003");
		`CHK(n_clear, n0 + 1)
		`CHK(rxq.size(), r0)
		`CHK(dtr_pin, 1'b1)
		`CHK(talk_active, 1'b0)
		`CHK(rx_full, 1'b0)
		dsr_pin = 1'b1;
		repeat (5 * 11 * DIV) @(negedge clk);
		`CHK(i_shfc_host_model.got_q.size(), 0)
	endtask : t_cancel

	initial begin
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		`CHK(dtr_pin, 1'b1)
		t_modes();
		t_rx();
		t_parity();
		t_query();
		t_full();
		t_cancel();
		give_verdict();
	end

	// watchdog well beyond the expected run of about 150 us
	initial begin
		#400000;
		failures++;
		give_verdict();
	end
endmodule : tb
